/* design/pfts_sequencer.sv */
// Program flash table sequencer: table reads through a byte latch, table
// writes into 64 holding registers, unlocked block erase and programming.
// Assumes a same-clock core and a flash array that returns read data in
// the cycle its read enable is high.
//
// Contract
// - Table read fetches one byte into latch.
// - Pointer bit 0 selects high or low byte.
// - Table operations optionally step the pointer.
// - Erase always clears a 1024-byte block.
// - Erase block from pointer bit 10 up.
// - No larger erase from device code.
// - Start honoured only after 55h, AAh keys.
// - Start with erase selected erases block.
// - Core stalled until programming timer ends.
// - Programming always writes 64 bytes.
// - Table writes fill holding registers only.
// - Holding registers kept after programming.
// - Start bit set by software, hardware clears.
// - Erase-select chooses erase, cleared on completion.
// - Pointer low six bits index holding registers.
// - Abort flag set on start, cleared on completion.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module pfts_sequencer #(
   parameter int ERASE_CYCLES = pfts_pkg::ERASE_CYCLES,
   parameter int PROG_CYCLES  = pfts_pkg::PROG_CYCLES
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic                          powerOnRst_n,
   input  wire logic [pfts_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [pfts_pkg::DATA_W-1:0]   regWdata,
   input  wire logic                          regWrite,
   input  wire logic                          regRead,
   output logic      [pfts_pkg::DATA_W-1:0]   regRdata,
   input  wire logic                          tableReadOp,
   input  wire logic                          tableWriteOp,
   input  wire logic [1:0]                    tablePtrMode,
   output logic                               cpuStall,
   output logic      [pfts_pkg::PTR_W-2:0]    flashWordAddr,
   output logic                               flashReadEn,
   input  wire logic [pfts_pkg::WORD_W-1:0]   flashRdData,
   output logic                               flashEraseStart,
   output logic                               flashWordWrite,
   output logic      [pfts_pkg::WORD_W-1:0]   flashWordData
);

   logic [pfts_pkg::DATA_W-1:0]     holdReg_q [pfts_pkg::HOLD_N];
   pfts_pkg::pfts_state_e           state_q, state_d;
   pfts_pkg::pfts_key_e             key_q, key_d;
   logic [pfts_pkg::PTR_W-1:0]      ptr_q, ptr_d;
   logic [pfts_pkg::DATA_W-1:0]     latch_q, latch_d;
   logic [pfts_pkg::DATA_W-1:0]     rdata_q, rdata_d;
   logic                            start_q, start_d;
   logic                            enable_q, enable_d;
   logic                            erase_q, erase_d;
   logic                            abort_q, abort_d;
   logic                            stall_q, stall_d;
   logic                            readPend_q, readPend_d;
   logic                            readLane_q, readLane_d;
   logic [31:0]                     timer_q, timer_d;
   logic [pfts_pkg::WIDX_W-1:0]     wordIdx_q, wordIdx_d;
   logic [pfts_pkg::PTR_W-2:0]      fAddr_q, fAddr_d;
   logic                            fRead_q, fRead_d;
   logic                            fErase_q, fErase_d;
   logic                            fWrite_q, fWrite_d;
   logic [pfts_pkg::WORD_W-1:0]     fData_q, fData_d;
   logic                            holdWe;
   logic [pfts_pkg::HOLD_IDX_W-1:0] holdIdx;
   logic [pfts_pkg::PTR_W-1:0]      ptrInc, ptrDec, ptrUsed, ptrAfter;

   // Pointer arithmetic touches only the low 21 bits.
   assign ptrInc = {ptr_q[21], 21'(ptr_q[20:0] + 21'h000001)};
   assign ptrDec = {ptr_q[21], 21'(ptr_q[20:0] - 21'h000001)};

   // Address used by a table operation and the pointer left behind.
   always_comb
   begin
      ptrUsed  = ptr_q;
      ptrAfter = ptr_q;
      case (pfts_pkg::pfts_ptr_mode_e'(tablePtrMode))
         pfts_pkg::PTR_POST_INC: ptrAfter = ptrInc;
         pfts_pkg::PTR_POST_DEC: ptrAfter = ptrDec;
         pfts_pkg::PTR_PRE_INC:
         begin
            ptrUsed  = ptrInc;
            ptrAfter = ptrInc;
         end
         default: ptrAfter = ptr_q;
      endcase
   end

   // Next values of the sequencer, registers and flash strobes.
   always_comb
   begin
      state_d    = state_q;
      key_d      = key_q;
      ptr_d      = ptr_q;
      latch_d    = latch_q;
      start_d    = start_q;
      enable_d   = enable_q;
      erase_d    = erase_q;
      abort_d    = abort_q;
      stall_d    = stall_q;
      readPend_d = 1'b0;
      readLane_d = readLane_q;
      timer_d    = timer_q;
      wordIdx_d  = wordIdx_q;
      fAddr_d    = fAddr_q;
      fRead_d    = 1'b0;
      fErase_d   = 1'b0;
      fWrite_d   = 1'b0;
      fData_d    = fData_q;
      holdWe     = 1'b0;
      holdIdx    = ptrUsed[5:0];
      // Array data of the previous read lands in the latch.
      if (readPend_q)
      begin
         latch_d = readLane_q ? flashRdData[15:8] : flashRdData[7:0];
      end
      case (state_q)
         pfts_pkg::ST_IDLE:
         begin
            if (tableReadOp)
            begin
               fAddr_d    = ptrUsed[21:1];
               fRead_d    = 1'b1;
               readPend_d = 1'b1;
               readLane_d = ptrUsed[0];
               ptr_d      = ptrAfter;
            end
            else if (tableWriteOp)
            begin
               holdWe = 1'b1;
               ptr_d  = ptrAfter;
            end
            if (regWrite)
            begin
               key_d = pfts_pkg::KEY_NONE;
               if (regAddr == pfts_pkg::OFS_KEY)
               begin
                  if (regWdata == pfts_pkg::KEY_FIRST)
                  begin
                     key_d = pfts_pkg::KEY_GOT1;
                  end
                  else if (regWdata == pfts_pkg::KEY_SECOND && key_q == pfts_pkg::KEY_GOT1)
                  begin
                     key_d = pfts_pkg::KEY_GOT2;
                  end
               end
               else if (regAddr == pfts_pkg::OFS_CONTROL)
               begin
                  enable_d = regWdata[pfts_pkg::BIT_EN];
                  erase_d  = regWdata[pfts_pkg::BIT_ERASE];
                  abort_d  = regWdata[pfts_pkg::BIT_ABORT];
                  if (regWdata[pfts_pkg::BIT_START])
                  begin
                     abort_d = 1'b1;
                     if (key_q == pfts_pkg::KEY_GOT2 && regWdata[pfts_pkg::BIT_EN])
                     begin
                        start_d = 1'b1;
                        stall_d = 1'b1;
                        if (regWdata[pfts_pkg::BIT_ERASE])
                        begin
                           fAddr_d  = {ptr_q[21:10], 9'h000};
                           fErase_d = 1'b1;
                           timer_d  = 32'(ERASE_CYCLES - 1);
                           state_d  = pfts_pkg::ST_ERASE;
                        end
                        else
                        begin
                           wordIdx_d = '0;
                           state_d   = pfts_pkg::ST_SEND;
                        end
                     end
                  end
               end
               else if (regAddr == pfts_pkg::OFS_LATCH)
               begin
                  latch_d = regWdata;
               end
               else if (regAddr == pfts_pkg::OFS_PTR_LO)
               begin
                  ptr_d[7:0] = regWdata;
               end
               else if (regAddr == pfts_pkg::OFS_PTR_MID)
               begin
                  ptr_d[15:8] = regWdata;
               end
               else if (regAddr == pfts_pkg::OFS_PTR_UP)
               begin
                  ptr_d[21:16] = regWdata[5:0];
               end
            end
         end
         pfts_pkg::ST_SEND:
         begin
            // One word per cycle from the holding registers, low byte even.
            fWrite_d  = 1'b1;
            fAddr_d   = {ptr_q[21:6], wordIdx_q};
            fData_d   = {holdReg_q[{wordIdx_q, 1'b1}], holdReg_q[{wordIdx_q, 1'b0}]};
            wordIdx_d = 5'(wordIdx_q + 5'h01);
            if (wordIdx_q == pfts_pkg::LAST_WORD)
            begin
               timer_d = 32'(PROG_CYCLES - 1);
               state_d = pfts_pkg::ST_WAIT;
            end
         end
         pfts_pkg::ST_WAIT, pfts_pkg::ST_ERASE:
         begin
            if (timer_q == 32'h00000000)
            begin
               start_d = 1'b0;
               abort_d = 1'b0;
               stall_d = 1'b0;
               if (state_q == pfts_pkg::ST_ERASE)
               begin
                  erase_d = 1'b0;
               end
               state_d = pfts_pkg::ST_IDLE;
            end
            else
            begin
               timer_d = timer_q - 32'h00000001;
            end
         end
         default: state_d = pfts_pkg::ST_IDLE;
      endcase
   end

   // Read data for the register port, zero when no read is made.
   always_comb
   begin
      rdata_d = 8'h00;
      if (regRead)
      begin
         if (regAddr == pfts_pkg::OFS_CONTROL)
         begin
            rdata_d = {3'h0, erase_q, abort_q, enable_q, start_q, 1'b0};
         end
         else if (regAddr == pfts_pkg::OFS_LATCH)
         begin
            rdata_d = latch_q;
         end
         else if (regAddr == pfts_pkg::OFS_PTR_LO)
         begin
            rdata_d = ptr_q[7:0];
         end
         else if (regAddr == pfts_pkg::OFS_PTR_MID)
         begin
            rdata_d = ptr_q[15:8];
         end
         else if (regAddr == pfts_pkg::OFS_PTR_UP)
         begin
            rdata_d = {2'h0, ptr_q[21:16]};
         end
      end
   end

   // Registers of the sequencer and register file.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q    <= pfts_pkg::ST_IDLE;
         key_q      <= pfts_pkg::KEY_NONE;
         ptr_q      <= '0;
         latch_q    <= 8'h00;
         rdata_q    <= 8'h00;
         start_q    <= 1'b0;
         enable_q   <= 1'b0;
         erase_q    <= 1'b0;
         stall_q    <= 1'b0;
         readPend_q <= 1'b0;
         readLane_q <= 1'b0;
         timer_q    <= 32'h00000000;
         wordIdx_q  <= 5'h00;
         fAddr_q    <= '0;
         fRead_q    <= 1'b0;
         fErase_q   <= 1'b0;
         fWrite_q   <= 1'b0;
         fData_q    <= 16'h0000;
      end
      else
      begin
         state_q    <= state_d;
         key_q      <= key_d;
         ptr_q      <= ptr_d;
         latch_q    <= latch_d;
         rdata_q    <= rdata_d;
         start_q    <= start_d;
         enable_q   <= enable_d;
         erase_q    <= erase_d;
         stall_q    <= stall_d;
         readPend_q <= readPend_d;
         readLane_q <= readLane_d;
         timer_q    <= timer_d;
         wordIdx_q  <= wordIdx_d;
         fAddr_q    <= fAddr_d;
         fRead_q    <= fRead_d;
         fErase_q   <= fErase_d;
         fWrite_q   <= fWrite_d;
         fData_q    <= fData_d;
      end
   end

   // Abort flag survives the ordinary reset so an aborted write shows.
   always_ff @(posedge ref_clk or negedge powerOnRst_n)
   begin
      if (!powerOnRst_n)
      begin
         abort_q <= 1'b0;
      end
      else
      begin
         abort_q <= rst_n ? abort_d : abort_q;
      end
   end

   // Holding registers, written only by table writes and never cleared
   // by programming.
   generate
      for (genvar i = 0; i < pfts_pkg::HOLD_N; i++)
      begin : g_hold
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               holdReg_q[i] <= 8'h00;
            end
            else if (holdWe && holdIdx == 6'(i))
            begin
               holdReg_q[i] <= latch_q;
            end
         end
      end
   endgenerate

   assign regRdata        = rdata_q;
   assign cpuStall        = stall_q;
   assign flashWordAddr   = fAddr_q;
   assign flashReadEn     = fRead_q;
   assign flashEraseStart = fErase_q;
   assign flashWordWrite  = fWrite_q;
   assign flashWordData   = fData_q;

endmodule : pfts_sequencer

/* design/pfts_pkg.sv */
// Package for the program flash table sequencer: register map, field
// positions, key values, timing counts and state enumerations.
// Assumes an 8-bit register port with a 4-bit address and a 200 MHz clock.
package pfts_pkg;

   // Widths of the pointer, register port, holding buffer and array words.
   localparam int PTR_W      = 22;
   localparam int ADDR_W     = 4;
   localparam int DATA_W     = 8;
   localparam int WORD_W     = 16;
   localparam int HOLD_N     = 64;
   localparam int HOLD_IDX_W = 6;
   localparam int WIDX_W     = 5;
   localparam logic [WIDX_W-1:0] LAST_WORD = 5'h1F;

   // Register offsets on the register port.
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_KEY     = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_LATCH   = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_PTR_LO  = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_PTR_MID = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_PTR_UP  = 4'h5;

   // Field positions in the flash control register.
   localparam int BIT_START = 1;
   localparam int BIT_EN    = 2;
   localparam int BIT_ABORT = 3;
   localparam int BIT_ERASE = 4;

   // Unlock key values.
   localparam logic [DATA_W-1:0] KEY_FIRST  = 8'h55;
   localparam logic [DATA_W-1:0] KEY_SECOND = 8'hAA;

   // Long write durations and their cycle counts at the clock rate.
   localparam int CLK_PERIOD_NS = 5;
   localparam int ERASE_TIME_NS = 2000000;
   localparam int PROG_TIME_NS  = 2000000;
   localparam int ERASE_CYCLES  = ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;

   // Pointer update modes of a table operation.
   typedef enum logic [1:0] {
      PTR_KEEP     = 2'h0,
      PTR_POST_INC = 2'h1,
      PTR_POST_DEC = 2'h2,
      PTR_PRE_INC  = 2'h3
   } pfts_ptr_mode_e;

   // Sequencer states, Gray coded along the idle, send, wait path.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SEND  = 3'h1,
      ST_WAIT  = 3'h3,
      ST_ERASE = 3'h4
   } pfts_state_e;

   // Progress through the unlock key sequence.
   typedef enum logic [1:0] {
      KEY_NONE = 2'h0,
      KEY_GOT1 = 2'h1,
      KEY_GOT2 = 2'h3
   } pfts_key_e;

endpackage : pfts_pkg

/* test/pfts_flash_model.sv */
// Behavioural flash array on the far side of the sequencer's array port.
// Assumes read data is wanted in the same cycle as the read enable.
`timescale 1ns/1ps
module pfts_flash_model (
   input  wire logic                        ref_clk,
   input  wire logic [pfts_pkg::PTR_W-2:0]  flashWordAddr,
   input  wire logic                        flashReadEn,
   output logic      [pfts_pkg::WORD_W-1:0] flashRdData,
   input  wire logic                        flashEraseStart,
   input  wire logic                        flashWordWrite,
   input  wire logic [pfts_pkg::WORD_W-1:0] flashWordData
);
   logic [15:0] mem [0:1023];
   logic [15:0] junk;
   int          eraseCount;
   int          wordCount;
   // Seeds each word so that its two bytes differ.
   initial
   begin
      junk = 16'h0000;
      eraseCount = 0;
      wordCount = 0;
      for (int i = 0; i < 1024; i++)
         mem[i] = {i[7:0] ^ 8'h5A, i[7:0]};
   end
   // Outside a read the data lines wander, so stale values never match.
   assign flashRdData = flashReadEn ? mem[flashWordAddr[9:0]] : junk;
   // Erase sets a 512-word block; programming can only clear bits.
   always @(posedge ref_clk)
   begin
      junk <= junk + 16'h3D1B;
      if (flashEraseStart)
      begin
         for (int j = 0; j < 512; j++)
            mem[{flashWordAddr[9], j[8:0]}] <= 16'hFFFF;
         eraseCount <= eraseCount + 1;
      end
      if (flashWordWrite)
      begin
         mem[flashWordAddr[9:0]] <= mem[flashWordAddr[9:0]] & flashWordData;
         wordCount <= wordCount + 1;
      end
   end
endmodule : pfts_flash_model

/* test/pfts_sequencer_asserts.sv */
// Concurrent checks on the flash table sequencer's ports.
// Assumes it is bound into pfts_sequencer with the same count parameters.
`timescale 1ns/1ps
module pfts_sequencer_asserts #(
   parameter int ERASE_CYCLES = pfts_pkg::ERASE_CYCLES,
   parameter int PROG_CYCLES  = pfts_pkg::PROG_CYCLES
) (
   input wire logic                        ref_clk,
   input wire logic                        rst_n,
   input wire logic [pfts_pkg::ADDR_W-1:0] regAddr,
   input wire logic [pfts_pkg::DATA_W-1:0] regWdata,
   input wire logic                        regWrite,
   input wire logic                        regRead,
   input      logic [pfts_pkg::DATA_W-1:0] regRdata,
   input wire logic                        tableReadOp,
   input      logic                        cpuStall,
   input      logic [pfts_pkg::PTR_W-2:0]  flashWordAddr,
   input      logic                        flashReadEn,
   input      logic                        flashEraseStart,
   input      logic                        flashWordWrite
);
   localparam int MinStall = (ERASE_CYCLES < PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
   logic [7:0]  runQ, runD;
   logic [31:0] stallQ, stallD;
   logic        key1Q, key1D, key2Q, key2D, ctlStart;
   // Counts burst words and stall cycles and follows the unlock keys.
   always_comb
   begin
      runD = flashWordWrite ? runQ + 8'h01 : 8'h00;
      stallD = cpuStall ? stallQ + 32'h1 : 32'h0;
      key1D = key1Q;
      key2D = key2Q;
      if (regWrite && !cpuStall)
      begin
         key1D = regAddr == pfts_pkg::OFS_KEY && regWdata == pfts_pkg::KEY_FIRST;
         key2D = key1Q && regAddr == pfts_pkg::OFS_KEY && regWdata == pfts_pkg::KEY_SECOND;
      end
   end
   // Registers the helper state.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         runQ <= 8'h00;
         stallQ <= 32'h0;
         key1Q <= 1'b0;
         key2Q <= 1'b0;
      end
      else
      begin
         runQ <= runD;
         stallQ <= stallD;
         key1Q <= key1D;
         key2Q <= key2D;
      end
   end
   // A control write that asks for a start.
   assign ctlStart = regWrite && !cpuStall && regAddr == pfts_pkg::OFS_CONTROL
                     && regWdata[pfts_pkg::BIT_START];
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   property p_read_one;
      tableReadOp && !cpuStall && !flashWordWrite && !flashReadEn |=> flashReadEn
         ##1 (!flashReadEn || $past(tableReadOp));
   endproperty
   a_read_one: assert property (p_read_one)
      else $error("table read did not give one array read");
   property p_no_read_stall;
      cpuStall |-> !flashReadEn;
   endproperty
   a_no_read_stall: assert property (p_no_read_stall)
      else $error("array read while stalled");
   property p_erase_addr;
      flashEraseStart |-> flashWordAddr[8:0] == 9'h000 && cpuStall ##1 !flashEraseStart;
   endproperty
   a_erase_addr: assert property (p_erase_addr)
      else $error("erase address or pulse wrong");
   property p_prog_len;
      $fell(flashWordWrite) |-> runQ == 8'h20;
   endproperty
   a_prog_len: assert property (p_prog_len)
      else $error("program burst not 32 words");
   property p_prog_idx;
      flashWordWrite |-> runQ < 8'h20 && flashWordAddr[4:0] == runQ[4:0] && cpuStall;
   endproperty
   a_prog_idx: assert property (p_prog_idx)
      else $error("program word index wrong");
   property p_prog_base;
      flashWordWrite && $past(flashWordWrite) |-> $stable(flashWordAddr[20:5]);
   endproperty
   a_prog_base: assert property (p_prog_base)
      else $error("program block moved in burst");
   property p_stall_len;
      $fell(cpuStall) |-> stallQ >= MinStall;
   endproperty
   a_stall_len: assert property (p_stall_len)
      else $error("stall ended early");
   property p_key_zero;
      regRead && regAddr == pfts_pkg::OFS_KEY |=> regRdata == 8'h00;
   endproperty
   a_key_zero: assert property (p_key_zero)
      else $error("key port read not zero");
   property p_start_go;
      ctlStart && key2Q && regWdata[pfts_pkg::BIT_EN] |=> cpuStall
         && flashEraseStart == $past(regWdata[pfts_pkg::BIT_ERASE])
         ##1 flashWordWrite == !$past(regWdata[pfts_pkg::BIT_ERASE], 2);
   endproperty
   a_start_go: assert property (p_start_go)
      else $error("unlocked start did not launch");
   property p_start_gate;
      ctlStart && !(key2Q && regWdata[pfts_pkg::BIT_EN]) |=> !cpuStall
         && !flashEraseStart && !flashWordWrite;
   endproperty
   a_start_gate: assert property (p_start_gate)
      else $error("locked start launched");
endmodule : pfts_sequencer_asserts

/* test/testbench.sv */
// Self-checking bench for the flash table sequencer with an array model.
// Assumes short long-write counts of 20 cycles.
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [21:0] ptr; logic [1:0] mode; logic [7:0] lat; logic [21:0] nxt;} pfts_row_s;
   logic        ref_clk, rst_n, powerOnRst_n, regWrite, regRead, tableReadOp, tableWriteOp;
   logic [3:0]  regAddr;
   logic [7:0]  regWdata, regRdata, d;
   logic [1:0]  tablePtrMode;
   logic [20:0] flashWordAddr;
   logic [15:0] flashRdData, flashWordData;
   logic [21:0] p;
   logic        cpuStall, flashReadEn, flashEraseStart, flashWordWrite;
   int          fails, checked;
   pfts_row_s   rows [0:6] = '{'{22'h000010, 2'h0, 8'h08, 22'h000010},
      '{22'h000011, 2'h1, 8'h52, 22'h000012}, '{22'h000021, 2'h2, 8'h4A, 22'h000020},
      '{22'h00002F, 2'h3, 8'h18, 22'h000030}, '{22'h000000, 2'h2, 8'h00, 22'h1FFFFF},
      '{22'h200001, 2'h1, 8'h5A, 22'h200002}, '{22'h3FFFFF, 2'h3, 8'h00, 22'h200000}};
   pfts_sequencer #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) dut (.ref_clk, .rst_n, .powerOnRst_n,
      .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .tableReadOp, .tableWriteOp,
      .tablePtrMode, .cpuStall, .flashWordAddr, .flashReadEn, .flashRdData, .flashEraseStart,
      .flashWordWrite, .flashWordData);
   pfts_flash_model flash (.ref_clk, .flashWordAddr, .flashReadEn, .flashRdData,
      .flashEraseStart, .flashWordWrite, .flashWordData);
   // Free-running 200 MHz clock.
   always #2.5 ref_clk = ~ref_clk;
   // Comparison, bus and sequence helpers.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 v = regRdata;
   endtask : rd
   task automatic setPtr(input logic [21:0] v);
      wr(pfts_pkg::OFS_PTR_LO, v[7:0]);
      wr(pfts_pkg::OFS_PTR_MID, v[15:8]);
      wr(pfts_pkg::OFS_PTR_UP, {2'b00, v[21:16]});
   endtask : setPtr
   task automatic getPtr(output logic [21:0] v);
      logic [7:0] b0, b1, b2;
      rd(pfts_pkg::OFS_PTR_LO, b0);
      rd(pfts_pkg::OFS_PTR_MID, b1);
      rd(pfts_pkg::OFS_PTR_UP, b2);
      v = {b2[5:0], b1, b0};
   endtask : getPtr
   task automatic tbl(input logic isRead, input logic [1:0] m);
      @(posedge ref_clk);
      tableReadOp <= isRead;
      tableWriteOp <= !isRead;
      tablePtrMode <= m;
      @(posedge ref_clk);
      tableReadOp <= 1'b0;
      tableWriteOp <= 1'b0;
      @(posedge ref_clk);
   endtask : tbl
   task automatic launch(input logic [7:0] ctl);
      wr(pfts_pkg::OFS_KEY, 8'h55);
      wr(pfts_pkg::OFS_KEY, 8'hAA);
      wr(pfts_pkg::OFS_CONTROL, ctl);
      @(posedge ref_clk);
      #1;
      for (int n = 0; n < 500 && cpuStall !== 1'b0; n++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk("stall released", cpuStall, 1'b0);
   endtask : launch
   task automatic results;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   // Cuts a hung run short.
   initial
   begin
      #100000;
      fails++;
      results();
   end
   // Main sequence: reset, table read rows, then erase, program and faults.
   initial
   begin
      {ref_clk, rst_n, powerOnRst_n, regWrite, regRead, tableReadOp, tableWriteOp} = 7'h00;
      {regAddr, regWdata, tablePtrMode} = 14'h0000;
      fails = 0;
      checked = 0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      powerOnRst_n <= 1'b1;
      rd(pfts_pkg::OFS_CONTROL, d);
      chk("control at reset", d, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, d);
      chk("unmapped", d, 8'h00);
      wr(pfts_pkg::OFS_KEY, pfts_pkg::KEY_FIRST);
      rd(pfts_pkg::OFS_KEY, d);
      chk("key read", d, 8'h00);
      $display("reset test done");
      foreach (rows[i])
      begin
         setPtr(rows[i].ptr);
         tbl(1'b1, rows[i].mode);
         rd(pfts_pkg::OFS_LATCH, d);
         chk("latch", d, rows[i].lat);
         getPtr(p);
         chk("pointer", p, rows[i].nxt);
      end
      $display("table read rows done");
      setPtr(22'h0007FF);
      launch(8'h16);
      rd(pfts_pkg::OFS_CONTROL, d);
      chk("control after erase", d, 8'h04);
      chk("erase low", flash.mem[10'h200], 16'hFFFF);
      chk("erase high", flash.mem[10'h3FF], 16'hFFFF);
      chk("erase below", flash.mem[10'h1FF], 16'hA5FF);
      chk("erase count", flash.eraseCount, 1);
      $display("erase test done");
      setPtr(22'h000440);
      for (int i = 0; i < 64; i++)
      begin
         wr(pfts_pkg::OFS_LATCH, 8'(i) ^ 8'h33);
         tbl(1'b0, 2'h1);
      end
      chk("array untouched", flash.wordCount, 0);
      for (int k = 0; k < 2; k++)
      begin
         setPtr(k ? 22'h000480 : 22'h000447);
         launch(8'h06);
         chk("words written", flash.wordCount, 32 * (k + 1));
         for (int j = 0; j < 32; j++)
            chk("programmed", flash.mem[10'h220 + 32 * k + j],
                {8'(2 * j + 1) ^ 8'h33, 8'(2 * j) ^ 8'h33});
         rd(pfts_pkg::OFS_CONTROL, d);
         chk("control after program", d, 8'h04);
      end
      $display("program test done");
      for (int c = 0; c < 3; c++)
      begin
         if (c > 0)
         begin
            wr(pfts_pkg::OFS_KEY, 8'h55);
            wr(pfts_pkg::OFS_KEY, 8'hAA);
         end
         if (c == 2)
            wr(pfts_pkg::OFS_PTR_LO, 8'h00);
         wr(pfts_pkg::OFS_CONTROL, c == 1 ? 8'h02 : 8'h06);
         @(posedge ref_clk);
         #1 chk("refused stall", cpuStall, 1'b0);
         rd(pfts_pkg::OFS_CONTROL, d);
         chk("refused abort", d & 8'h08, 8'h08);
         wr(pfts_pkg::OFS_CONTROL, 8'h00);
         chk("refused words", flash.wordCount, 64);
      end
      $display("refusal test done");
      launch(8'h00);
      wr(pfts_pkg::OFS_KEY, 8'h55);
      wr(pfts_pkg::OFS_KEY, 8'hAA);
      wr(pfts_pkg::OFS_CONTROL, 8'h16);
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(pfts_pkg::OFS_CONTROL, d);
      chk("abort kept", d, 8'h08);
      @(posedge ref_clk);
      powerOnRst_n <= 1'b0;
      @(posedge ref_clk);
      powerOnRst_n <= 1'b1;
      rd(pfts_pkg::OFS_CONTROL, d);
      chk("abort cleared", d, 8'h00);
      $display("abort test done");
      results();
   end
endmodule : testbench
bind pfts_sequencer pfts_sequencer_asserts #(.ERASE_CYCLES(ERASE_CYCLES),
   .PROG_CYCLES(PROG_CYCLES)) chkr (.ref_clk, .rst_n, .regAddr, .regWdata, .regWrite,
   .regRead, .regRdata, .tableReadOp, .cpuStall, .flashWordAddr, .flashReadEn,
   .flashEraseStart, .flashWordWrite);
